/* File: hw/dcd_ctrl.sv */
// Memory controller end: request to pin encoding, init wait, burst data
`timescale 1ns/1ps
`default_nettype none
module dcd_ctrl #(
  parameter int INIT_CYCLES = dcd_pkg::INIT_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  dcd_if.ctrl ddr,
  input wire logic req_valid,
  input wire dcd_pkg::dcd_req_t req_kind,
  input wire logic [dcd_pkg::BA_W-1:0] req_bank,
  input wire logic [dcd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [dcd_pkg::BURST_W-1:0] req_wdata,
  input wire logic [dcd_pkg::MASK_W-1:0] req_wmask,
  output logic req_ready,
  output logic rsp_valid,
  output logic [dcd_pkg::BURST_W-1:0] rsp_rdata,
  output logic init_done
);
  typedef enum {C_INIT, C_IDLE, C_WDATA, C_RWAIT} dcd_cst_t;

  dcd_cst_t st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] pins_q, pins_d;
  logic cke_q, cke_d;
  logic [dcd_pkg::BA_W-1:0] ba_q, ba_d;
  logic [dcd_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [dcd_pkg::DM_W-1:0] dm_q, dm_d;
  logic [dcd_pkg::PAIR_W-1:0] dq_o_q, dq_o_d;
  logic oe_n_q, oe_n_d;
  logic [dcd_pkg::BURST_W-1:0] wdata_q, wdata_d;
  logic [dcd_pkg::MASK_W-1:0] wmask_q, wmask_d;
  logic [dcd_pkg::BURST_W-1:0] rdata_q, rdata_d;
  logic [dcd_pkg::ADDR_W-1:0] mr0_q, mr0_d;
  logic [1:0] blast_q, blast_d;
  logic rsp_q, rsp_d;
  logic [1:0] pair;
  logic take;

  assign req_ready = (st_q == C_IDLE);
  assign take = req_valid && req_ready;

  // Request encoding, init wait and data sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_DES);
    cke_d = cke_q;
    ba_d = ba_q;
    addr_d = addr_q;
    dm_d = dm_q;
    dq_o_d = dq_o_q;
    oe_n_d = 1'b1;
    wdata_d = wdata_q;
    wmask_d = wmask_q;
    rdata_d = rdata_q;
    mr0_d = mr0_q;
    blast_d = blast_q;
    rsp_d = 1'b0;
    pair = cnt_q[1:0];
    case (st_q)
      C_INIT: begin
        // Enable stays low until the wait ends, then rises on a no-operation
        if (cnt_q == 16'(INIT_CYCLES - 1)) begin
          st_d = C_IDLE;
          cke_d = 1'b1;
          pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_NOP);
        end else begin
          cnt_d = 16'(cnt_q + 16'h1);
        end
      end
      C_IDLE: begin
        if (take) begin
          ba_d = req_bank;
          addr_d = req_addr;
          cnt_d = 16'h0;
          if (!cke_q) begin
            // Only wake-up requests act while the enable is low
            if (req_kind == dcd_pkg::REQ_PDX || req_kind == dcd_pkg::REQ_SRX) begin
              cke_d = 1'b1;
              pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_NOP);
            end
          end else begin
            case (req_kind)
              dcd_pkg::REQ_NOP: pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_NOP);
              dcd_pkg::REQ_ACT: pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_ACT);
              dcd_pkg::REQ_PRE: pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_PRE);
              dcd_pkg::REQ_REF: pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_REF);
              dcd_pkg::REQ_ZQ: pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_ZQ);
              dcd_pkg::REQ_MRS: begin
                pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_MRS);
                // Track the burst setting so data phases match the device
                if (req_bank == '0) begin
                  mr0_d = req_addr;
                end
              end
              dcd_pkg::REQ_PDE: begin
                pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_NOP);
                cke_d = 1'b0;
              end
              dcd_pkg::REQ_SRE: begin
                pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_REF);
                cke_d = 1'b0;
              end
              dcd_pkg::REQ_WR, dcd_pkg::REQ_RD: begin
                blast_d = dcd_pkg::burst_is_four(mr0_q, req_addr[dcd_pkg::BC_BIT])
                          ? dcd_pkg::LAST_PAIR_CHOP : dcd_pkg::LAST_PAIR_FULL;
                if (req_kind == dcd_pkg::REQ_WR) begin
                  pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_WR);
                  wdata_d = req_wdata;
                  wmask_d = req_wmask;
                  st_d = C_WDATA;
                end else begin
                  pins_d = dcd_pkg::cmd_pins(dcd_pkg::CMD_RD);
                  rdata_d = '0;
                  st_d = C_RWAIT;
                end
              end
              default: ;
            endcase
          end
        end
      end
      C_WDATA: begin
        // One pair of beats per clock, first pair right after the command
        dq_o_d = wdata_q[{pair, 5'h00} +: dcd_pkg::PAIR_W];
        dm_d = wmask_q[{pair, 2'h0} +: dcd_pkg::DM_W];
        oe_n_d = 1'b0;
        cnt_d = 16'(cnt_q + 16'h1);
        if (pair == blast_q) begin
          st_d = C_IDLE;
        end
      end
      C_RWAIT: begin
        // Fixed read timing: pairs show from the second clock after the command
        cnt_d = 16'(cnt_q + 16'h1);
        if (cnt_q[2:0] >= dcd_pkg::READ_SKIP) begin
          pair = 2'(cnt_q[2:0] - dcd_pkg::READ_SKIP);
          rdata_d[{pair, 5'h00} +: dcd_pkg::PAIR_W] = ddr.dq;
          if (pair == blast_q) begin
            rsp_d = 1'b1;
            st_d = C_IDLE;
          end
        end
      end
      default: st_d = C_INIT;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= C_INIT;
      cnt_q <= 16'h0;
      pins_q <= 4'hf;
      cke_q <= 1'b0;
      ba_q <= '0;
      addr_q <= '0;
      dm_q <= '0;
      dq_o_q <= '0;
      oe_n_q <= 1'b1;
      wdata_q <= '0;
      wmask_q <= '0;
      rdata_q <= '0;
      mr0_q <= dcd_pkg::ADDR_RESET;
      blast_q <= 2'h0;
      rsp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      cke_q <= cke_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      dm_q <= dm_d;
      dq_o_q <= dq_o_d;
      oe_n_q <= oe_n_d;
      wdata_q <= wdata_d;
      wmask_q <= wmask_d;
      rdata_q <= rdata_d;
      mr0_q <= mr0_d;
      blast_q <= blast_d;
      rsp_q <= rsp_d;
    end
  end

  assign {ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n} = pins_q;
  assign ddr.cke = cke_q;
  assign ddr.ba = ba_q;
  assign ddr.addr = addr_q;
  assign ddr.dm = dm_q;
  assign ddr.ctl_dq_o = dq_o_q;
  assign ddr.ctl_dq_oe_n = oe_n_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign init_done = (st_q != C_INIT);
endmodule
`default_nettype wire

/* File: hw/dcd_device.sv */
// DRAM device end: command decode, bank state, bursts and masked storage
//
// Behaviour
// - Activate latches bank and row of idle bank
// - Write strobe pattern with clock enable held high
// - On-the-fly write, chop bit low: four beats
// - On-the-fly write, chop bit high: eight beats
// - Read strobe pattern with clock enable held high
// - On-the-fly read: four or eight by chop bit
// - Column from address; bit 10 auto-precharges after burst
// - Mode register write when idle, bank selects register
// - Power-down entry: enable falls with no-operation
// - Power-down exit: enable rises with no-operation
// - Commands judged on previous and present enable
// - Masked beat bytes are discarded
// - Unmasked beat bytes are stored
// - Lower and upper masks gate own byte
// - Eight banks, independently open at once
// - Full access moves eight beats over four clocks, chopped access four over two
// - Two data words per clock on pins
// - Burst starts at column, eight or four, ordered
// - Chop bit honoured only in on-the-fly mode
// - Controller initialises before normal commands
`timescale 1ns/1ps
`default_nettype none
module dcd_device #(
  parameter int ROW_KEEP = 2
) (
  input wire logic clk,
  input wire logic resetn,
  dcd_if.dev ddr,
  output logic [dcd_pkg::BANKS-1:0] bank_open,
  output logic power_down,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic zq_pulse,
  output logic zq_long
);
  localparam int MEM_AW = dcd_pkg::BA_W + ROW_KEEP + dcd_pkg::COL_W;

  typedef enum {P_ON, P_DOWN, P_SELF} dcd_pwr_t;
  typedef enum {B_IDLE, B_WR, B_RD} dcd_burst_t;

  logic cke_q;
  dcd_pwr_t pst_q, pst_d;
  logic [dcd_pkg::BANKS-1:0] act_q, act_d;
  logic [dcd_pkg::ADDR_W-1:0] row_q [dcd_pkg::BANKS];
  logic [dcd_pkg::ADDR_W-1:0] row_d [dcd_pkg::BANKS];
  logic [dcd_pkg::ADDR_W-1:0] mr_q [dcd_pkg::MR_COUNT];
  logic [dcd_pkg::ADDR_W-1:0] mr_d [dcd_pkg::MR_COUNT];
  dcd_burst_t bst_q, bst_d;
  logic [1:0] bcnt_q, bcnt_d;
  logic [1:0] blast_q, blast_d;
  logic [dcd_pkg::BA_W-1:0] bbank_q, bbank_d;
  logic [dcd_pkg::ADDR_W-1:0] brow_q, brow_d;
  logic [dcd_pkg::COL_W-1:0] bcol_q, bcol_d;
  logic bap_q, bap_d;
  logic bchop_q, bchop_d;
  logic bilv_q, bilv_d;
  logic [dcd_pkg::PAIR_W-1:0] dq_o_q, dq_o_d;
  logic oe_n_q, oe_n_d;
  logic ref_q, ref_d;
  logic zq_q, zq_d;
  logic zql_q, zql_d;
  logic [dcd_pkg::DQ_W-1:0] mem [2**MEM_AW];

  dcd_pkg::dcd_cmd_t cmd;
  logic live;
  logic all_idle;
  logic chop;
  logic [MEM_AW-1:0] beat_addr [2];

  // Storage index of one beat of the running burst
  function automatic logic [MEM_AW-1:0] mem_addr(input logic [1:0] pair, input logic odd);
    logic [2:0] c3;
    c3 = dcd_pkg::burst_col(bcol_q[2:0], {pair, odd}, bchop_q, bilv_q);
    return {bbank_q, brow_q[ROW_KEEP-1:0], bcol_q[dcd_pkg::COL_W-1:3], c3};
  endfunction

  // Command decode against both enable samples
  always_comb begin
    cmd = dcd_pkg::cmd_decode({ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n});
    live = cke_q && ddr.cke;
    all_idle = (act_q == '0) && (bst_q == B_IDLE);
    chop = dcd_pkg::burst_is_four(mr_q[0], ddr.addr[dcd_pkg::BC_BIT]);
    beat_addr[0] = mem_addr(bcnt_q, 1'b0);
    beat_addr[1] = mem_addr(bcnt_q, 1'b1);
  end

  // Next state of power, banks, mode registers and burst engine
  always_comb begin
    pst_d = pst_q;
    act_d = act_q;
    row_d = row_q;
    mr_d = mr_q;
    bst_d = bst_q;
    bcnt_d = bcnt_q;
    blast_d = blast_q;
    bbank_d = bbank_q;
    brow_d = brow_q;
    bcol_d = bcol_q;
    bap_d = bap_q;
    bchop_d = bchop_q;
    bilv_d = bilv_q;
    ref_d = 1'b0;
    zq_d = 1'b0;
    zql_d = zql_q;
    dq_o_d = dq_o_q;
    oe_n_d = 1'b1;
    // Burst progress; auto-precharge closes the bank at the end
    if (bst_q != B_IDLE) begin
      if (bcnt_q == blast_q) begin
        bst_d = B_IDLE;
        bcnt_d = 2'h0;
        if (bap_q) begin
          act_d[bbank_q] = 1'b0;
        end
      end else begin
        bcnt_d = 2'(bcnt_q + 2'h1);
      end
    end
    // Read beats leave as one registered pair per clock
    if (bst_q == B_RD) begin
      dq_o_d = {mem[beat_addr[1]], mem[beat_addr[0]]};
      oe_n_d = 1'b0;
    end
    // Enable transitions pick power mode
    case (pst_q)
      P_ON: begin
        if (cke_q && !ddr.cke && bst_q == B_IDLE) begin
          if (cmd == dcd_pkg::CMD_REF && all_idle) begin
            pst_d = P_SELF;
          end else if (cmd == dcd_pkg::CMD_NOP || cmd == dcd_pkg::CMD_DES) begin
            pst_d = P_DOWN;
          end
        end
      end
      P_DOWN, P_SELF: begin
        if (!cke_q && ddr.cke && (cmd == dcd_pkg::CMD_NOP || cmd == dcd_pkg::CMD_DES)) begin
          pst_d = P_ON;
        end
      end
      default: pst_d = P_ON;
    endcase
    // Normal commands only with enable high in both samples
    if (pst_q == P_ON && live) begin
      case (cmd)
        dcd_pkg::CMD_ACT: begin
          if (!act_q[ddr.ba]) begin
            act_d[ddr.ba] = 1'b1;
            row_d[ddr.ba] = ddr.addr;
          end
        end
        dcd_pkg::CMD_PRE: begin
          if (ddr.addr[dcd_pkg::AP_BIT]) begin
            act_d = '0;
          end else begin
            act_d[ddr.ba] = 1'b0;
          end
        end
        dcd_pkg::CMD_WR, dcd_pkg::CMD_RD: begin
          // A column command during a running burst is dropped
          if (bst_q == B_IDLE && act_q[ddr.ba]) begin
            bst_d = (cmd == dcd_pkg::CMD_WR) ? B_WR : B_RD;
            bbank_d = ddr.ba;
            brow_d = row_q[ddr.ba];
            bcol_d = ddr.addr[dcd_pkg::COL_W-1:0];
            bap_d = ddr.addr[dcd_pkg::AP_BIT];
            bchop_d = chop;
            bilv_d = mr_q[0][dcd_pkg::MR0_BT_BIT];
            blast_d = chop ? dcd_pkg::LAST_PAIR_CHOP : dcd_pkg::LAST_PAIR_FULL;
            bcnt_d = 2'h0;
          end
        end
        dcd_pkg::CMD_MRS: begin
          if (all_idle && !ddr.ba[2]) begin
            mr_d[ddr.ba[1:0]] = ddr.addr;
          end
        end
        dcd_pkg::CMD_REF: begin
          ref_d = all_idle;
        end
        dcd_pkg::CMD_ZQ: begin
          if (all_idle) begin
            zq_d = 1'b1;
            zql_d = ddr.addr[dcd_pkg::AP_BIT];
          end
        end
        default: ; // No-operation and deselect leave state alone
      endcase
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cke_q <= 1'b0;
      pst_q <= P_ON;
      act_q <= '0;
      row_q <= '{default: dcd_pkg::ADDR_RESET};
      mr_q <= '{default: dcd_pkg::ADDR_RESET};
      bst_q <= B_IDLE;
      bcnt_q <= 2'h0;
      blast_q <= 2'h0;
      bbank_q <= '0;
      brow_q <= '0;
      bcol_q <= '0;
      bap_q <= 1'b0;
      bchop_q <= 1'b0;
      bilv_q <= 1'b0;
      dq_o_q <= '0;
      oe_n_q <= 1'b1;
      ref_q <= 1'b0;
      zq_q <= 1'b0;
      zql_q <= 1'b0;
    end else begin
      cke_q <= ddr.cke;
      pst_q <= pst_d;
      act_q <= act_d;
      row_q <= row_d;
      mr_q <= mr_d;
      bst_q <= bst_d;
      bcnt_q <= bcnt_d;
      blast_q <= blast_d;
      bbank_q <= bbank_d;
      brow_q <= brow_d;
      bcol_q <= bcol_d;
      bap_q <= bap_d;
      bchop_q <= bchop_d;
      bilv_q <= bilv_d;
      dq_o_q <= dq_o_d;
      oe_n_q <= oe_n_d;
      ref_q <= ref_d;
      zq_q <= zq_d;
      zql_q <= zql_d;
    end
  end

  // Array writes; no reset, contents are undefined until written
  always_ff @(posedge clk) begin
    if (bst_q == B_WR) begin
      for (int j = 0; j < 2; j++) begin
        for (int k = 0; k < 2; k++) begin
          if (!ddr.dm[2*j+k]) begin
            mem[beat_addr[j]][8*k +: 8] <= ddr.dq[dcd_pkg::DQ_W*j + 8*k +: 8];
          end
        end
      end
    end
  end

  assign ddr.dev_dq_o = dq_o_q;
  assign ddr.dev_dq_oe_n = oe_n_q;
  assign bank_open = act_q;
  assign power_down = (pst_q == P_DOWN);
  assign self_refresh = (pst_q == P_SELF);
  assign refresh_pulse = ref_q;
  assign zq_pulse = zq_q;
  assign zq_long = zql_q;
endmodule
`default_nettype wire

/* File: hw/dcd_if.sv */
// Pin bundle between memory controller and DRAM device
`timescale 1ns/1ps
`default_nettype none
interface dcd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [dcd_pkg::BA_W-1:0] ba;
  logic [dcd_pkg::ADDR_W-1:0] addr;
  logic [dcd_pkg::DM_W-1:0] dm;
  logic [dcd_pkg::PAIR_W-1:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [dcd_pkg::PAIR_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic [dcd_pkg::PAIR_W-1:0] dq;

  // Wire level of the shared data pins; device wins on a clash
  assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);

  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm, ctl_dq_o, ctl_dq_oe_n,
                input dq);
  modport dev (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dm, dq,
               output dev_dq_o, dev_dq_oe_n);
endinterface
`default_nettype wire

/* File: hw/dcd_pkg.sv */
// Shared constants, types and helpers for the DRAM command decode pair
package dcd_pkg;
  // Pin widths, counts and burst sizes
  localparam int BA_W = 3;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int PAIR_W = 2 * DQ_W;
  localparam int DM_W = 4;
  localparam int BANKS = 8;
  localparam int COL_W = 10;
  localparam int MR_COUNT = 4;
  localparam int PAIRS_MAX = 4;
  localparam int BURST_W = PAIRS_MAX * PAIR_W;
  localparam int MASK_W = PAIRS_MAX * DM_W;
  // Address bit positions
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // Mode register 0 burst fields
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BT_BIT = 3;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // Last pair index of a burst, counted in clocks
  localparam logic [1:0] LAST_PAIR_FULL = 2'h3;
  localparam logic [1:0] LAST_PAIR_CHOP = 2'h1;
  // Read data shows this many clocks after the command clock
  localparam logic [2:0] READ_SKIP = 3'h2;
  // Timing and address reset value
  localparam int CLK_MHZ = 50;
  localparam int INIT_WAIT_CYCLES = 16;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

  typedef enum {
    CMD_DES, CMD_NOP, CMD_ACT, CMD_PRE, CMD_WR, CMD_RD, CMD_MRS, CMD_REF, CMD_ZQ
  } dcd_cmd_t;

  // Four-state base so the request kind may travel on a wire port
  typedef enum logic [3:0] {
    REQ_NOP, REQ_ACT, REQ_PRE, REQ_WR, REQ_RD, REQ_MRS, REQ_REF, REQ_ZQ,
    REQ_PDE, REQ_PDX, REQ_SRE, REQ_SRX
  } dcd_req_t;

  // Strobe pattern {cs_n, ras_n, cas_n, we_n} to command
  function automatic dcd_cmd_t cmd_decode(input logic [3:0] s);
    dcd_cmd_t c;
    c = CMD_DES;
    if (!s[3]) begin
      case (s[2:0])
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h4: c = CMD_WR;
        3'h5: c = CMD_RD;
        3'h0: c = CMD_MRS;
        3'h1: c = CMD_REF;
        3'h6: c = CMD_ZQ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Command to strobe pattern {cs_n, ras_n, cas_n, we_n}
  function automatic logic [3:0] cmd_pins(input dcd_cmd_t c);
    logic [3:0] s;
    case (c)
      CMD_NOP: s = 4'h7;
      CMD_ACT: s = 4'h3;
      CMD_PRE: s = 4'h2;
      CMD_WR: s = 4'h4;
      CMD_RD: s = 4'h5;
      CMD_MRS: s = 4'h0;
      CMD_REF: s = 4'h1;
      CMD_ZQ: s = 4'h6;
      default: s = 4'hf;
    endcase
    return s;
  endfunction

  // Chop decision from mode register 0 and the chop address bit
  function automatic logic burst_is_four(input logic [ADDR_W-1:0] mr0, input logic bc);
    logic [1:0] bl;
    bl = mr0[MR0_BL_LSB +: 2];
    return (bl == BL_FIXED4) || ((bl == BL_OTF) && !bc);
  endfunction

  // Column low bits of one beat, sequential or interleaved order
  function automatic logic [2:0] burst_col(input logic [2:0] col, input logic [2:0] beat,
                                           input logic chop, input logic ilv);
    logic [2:0] s;
    s = ilv ? (col ^ beat) : 3'(col + beat);
    if (chop) begin
      s = {col[2], s[1:0]};
    end
    return s;
  endfunction
endpackage

/* File: verification/dcd_asserts.sv */
// Pin bundle assertions for the controller and device pair
`timescale 1ns/1ps
`default_nettype none
module dcd_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic ctl_dq_oe_n,
  input wire logic dev_dq_oe_n
);
  logic wr_c;
  logic rd_c;
  logic idle_c;
  // Decoded strobe patterns; deselect counts as idle
  assign wr_c = !cs_n && {ras_n, cas_n, we_n} == 3'h4;
  assign rd_c = !cs_n && {ras_n, cas_n, we_n} == 3'h5;
  assign idle_c = cs_n || {ras_n, cas_n, we_n} == 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_pd_entry_cmd: assert property ($fell(cke) |-> idle_c || {ras_n, cas_n, we_n} == 3'h1)
    else $error("enable fell without idle or refresh");
  a_pd_exit_cmd: assert property ($rose(cke) |-> idle_c)
    else $error("enable rose without idle");
  a_wr_data_follow: assert property (wr_c && cke |=> !ctl_dq_oe_n [*2])
    else $error("write data missing after write");
  a_wr_data_cause: assert property ($fell(ctl_dq_oe_n) |-> $past(wr_c && cke))
    else $error("write data without write");
  a_rd_data_follow: assert property (rd_c && cke && $past(cke) |-> ##2 !dev_dq_oe_n)
    else $error("read data missing after read");
  a_rd_data_cause: assert property ($fell(dev_dq_oe_n) |-> $past(rd_c, 2))
    else $error("read data without read");
  a_wr_burst_len: assert property ($fell(ctl_dq_oe_n) |->
    (!ctl_dq_oe_n [*2] ##1 ctl_dq_oe_n) or (!ctl_dq_oe_n [*4] ##1 ctl_dq_oe_n))
    else $error("write burst length wrong");
  a_rd_burst_len: assert property ($fell(dev_dq_oe_n) |->
    (!dev_dq_oe_n [*2] ##1 dev_dq_oe_n) or (!dev_dq_oe_n [*4] ##1 dev_dq_oe_n))
    else $error("read burst length wrong");
  a_no_bus_clash: assert property (ctl_dq_oe_n || dev_dq_oe_n)
    else $error("both ends drive data");
endmodule
`default_nettype wire

/* File: verification/tb_dram_command_decode.sv */
// Self-checking bench for the controller and device pair
`timescale 1ns/1ps
`default_nettype none
module tb_dram_command_decode;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  dcd_pkg::dcd_req_t req_kind = dcd_pkg::REQ_NOP;
  logic [2:0] req_bank = 3'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [127:0] req_wdata = 128'h0;
  logic [15:0] req_wmask = 16'h0000;
  logic req_ready, rsp_valid, init_done;
  logic [127:0] rsp_rdata;
  logic [7:0] bank_open;
  logic power_down, self_refresh, refresh_pulse, zq_pulse, zq_long;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [127:0] d0, d1, d2, mix, cur, swp;
  logic [15:0] msk = 16'h0009;

  dcd_if i_dcd_if ();
  dcd_ctrl #(.INIT_CYCLES(2)) i_dcd_ctrl (.clk(clk), .resetn(resetn), .ddr(i_dcd_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_wmask(req_wmask), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done));
  dcd_device i_dcd_device (.clk(clk), .resetn(resetn), .ddr(i_dcd_if), .bank_open(bank_open),
    .power_down(power_down), .self_refresh(self_refresh), .refresh_pulse(refresh_pulse),
    .zq_pulse(zq_pulse), .zq_long(zq_long));
  dcd_asserts i_dcd_asserts (.clk(clk), .resetn(resetn), .cs_n(i_dcd_if.cs_n),
    .ras_n(i_dcd_if.ras_n), .cas_n(i_dcd_if.cas_n), .we_n(i_dcd_if.we_n), .cke(i_dcd_if.cke),
    .ctl_dq_oe_n(i_dcd_if.ctl_dq_oe_n), .dev_dq_oe_n(i_dcd_if.dev_dq_oe_n));

  always #10 clk = ~clk;

  // Cycle ceiling so a stuck handshake still ends the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("mismatches=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held from a falling edge until a rising edge sees ready
  task automatic req(input dcd_pkg::dcd_req_t k, input logic [2:0] b, input logic [12:0] a,
                     input logic [127:0] d, input logic [15:0] m);
    int i;
    @(negedge clk);
    req_kind = k;
    req_bank = b;
    req_addr = a;
    req_wdata = d;
    req_wmask = m;
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    chk(128'(req_ready), 128'h1);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  // Read from bank 3, wait bounded for the response pulse
  task automatic rd(input logic [12:0] a, input logic [127:0] exp);
    int i;
    req(dcd_pkg::REQ_RD, 3'h3, a, 128'h0, 16'h0000);
    i = 0;
    while (rsp_valid !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    chk(128'(rsp_valid), 128'h1);
    chk(rsp_rdata, exp);
  endtask

  // Simple command, then a status check two cycles later
  task automatic cmd(input dcd_pkg::dcd_req_t k, input logic [2:0] b, input logic [12:0] a,
                     input logic [127:0] exp, input logic [127:0] got_sel);
    req(k, b, a, 128'h0, 16'h0000);
    repeat (2) @(negedge clk);
    chk(got_sel ? 128'({power_down, self_refresh}) : 128'(bank_open), exp);
  endtask

  initial begin
    d0 = 128'h0f0e0d0c_0b0a0908_07060504_03020100;
    d1 = 128'h1f1e1d1c_1b1a1918_17161514_13121110;
    d2 = 128'ha7a6a5a4_a3a2a1a0_afaeadac_abaaa9a8;
    // Masked bytes keep old data; chopped read leaves upper pairs zero
    for (int k = 0; k < 16; k++) begin
      mix[8*k +: 8] = (k > 7) ? 8'h00 : (msk[k] ? d1[8*k +: 8] : d2[8*k +: 8]);
    end
    // Row image after the masked write; interleaved read from column 1 swaps beats
    cur = {d1[127:64], mix[63:0]};
    for (int k = 0; k < 8; k++) begin
      swp[16*k +: 16] = cur[16*(k ^ 1) +: 16];
    end
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    chk(128'(init_done), 128'h1);
    cmd(dcd_pkg::REQ_ACT, 3'h3, 13'h1005, 128'h08, 128'h0);
    cmd(dcd_pkg::REQ_ACT, 3'h6, 13'h0002, 128'h48, 128'h0);
    // Fixed eight mode ignores a low chop bit
    req(dcd_pkg::REQ_WR, 3'h3, 13'h0000, d0, 16'h0000);
    rd(13'h0000, d0);
    cmd(dcd_pkg::REQ_PRE, 3'h6, 13'h0000, 128'h08, 128'h0);
    cmd(dcd_pkg::REQ_PRE, 3'h0, 13'h0400, 128'h00, 128'h0);
    req(dcd_pkg::REQ_MRS, 3'h0, 13'h0001, 128'h0, 16'h0000);
    cmd(dcd_pkg::REQ_ACT, 3'h3, 13'h1005, 128'h08, 128'h0);
    req(dcd_pkg::REQ_WR, 3'h3, 13'h1000, d1, 16'h0000);
    rd(13'h1000, d1);
    req(dcd_pkg::REQ_WR, 3'h3, 13'h0000, d2, msk);
    rd(13'h0400, mix);
    repeat (4) @(negedge clk);
    chk(128'(bank_open), 128'h00);
    // Interleaved on-the-fly, then fixed four ignoring a high chop bit
    for (int m = 0; m < 2; m++) begin
      req(dcd_pkg::REQ_MRS, 3'h0, m ? 13'h000a : 13'h0009, 128'h0, 16'h0000);
      cmd(dcd_pkg::REQ_ACT, 3'h3, 13'h1005, 128'h08, 128'h0);
      rd(13'h1401, m ? {64'h0, swp[63:0]} : swp);
    end
    cmd(dcd_pkg::REQ_NOP, 3'h5, 13'h0000, 128'h00, 128'h0);
    req(dcd_pkg::REQ_REF, 3'h0, 13'h0000, 128'h0, 16'h0000);
    @(negedge clk);
    chk(128'(refresh_pulse), 128'h1);
    // Long calibration first so the short one must clear the flag
    for (int k = 1; k >= 0; k--) begin
      req(dcd_pkg::REQ_ZQ, 3'h0, k[0] ? 13'h0400 : 13'h0000, 128'h0, 16'h0000);
      @(negedge clk);
      chk(128'({zq_pulse, zq_long}), 128'({1'b1, k[0]}));
    end
    cmd(dcd_pkg::REQ_PDE, 3'h0, 13'h0000, 128'h2, 128'h1);
    cmd(dcd_pkg::REQ_PDX, 3'h0, 13'h0000, 128'h0, 128'h1);
    cmd(dcd_pkg::REQ_SRE, 3'h0, 13'h0000, 128'h1, 128'h1);
    cmd(dcd_pkg::REQ_SRX, 3'h0, 13'h0000, 128'h0, 128'h1);
    close_out();
  end
endmodule
`default_nettype wire
